// >>> src/psl_loader.sv
// Serial latch loader: shift register, latch routing, reset and power-down
`default_nettype none
module psl_loader (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // Serial link pins
    input wire logic SCLK,
    input wire logic SDATA,
    input wire logic WORD_TRANSFER_STROBE,
    input wire logic CHIP_ENABLE,
    // Latch contents
    output logic [23:0] REF_LATCH,
    output logic [23:0] FB_LATCH,
    output logic [23:0] FUNC_LATCH,
    // Control and status
    output logic COUNTER_LOAD,
    output logic PUMP_TRISTATE,
    output logic POWER_DOWN,
    output logic LOCK_CLEAR,
    output logic INIT_RESET_PULSE,
    output logic SYNC_PD_REQ,
    output logic WORD_LOADED
);
    psl_link_if link ();

    psl_pin_sync u_sync (
        .clk(CLK),
        .reset(RESET),
        .sclk_pin(SCLK),
        .data_pin(SDATA),
        .strobe_pin(WORD_TRANSFER_STROBE),
        .ce_pin(CHIP_ENABLE),
        .link(link)
    );

    // ********************************************************************
    // Shift register
    // ********************************************************************
    logic [23:0] shift_r, shift_nxt;

    // Shifting runs regardless of power-down state
    always_comb begin
        shift_nxt = shift_r;
        if (link.sclk_rise) begin
            shift_nxt = {shift_r[22:0], link.data_s};
        end
    end

    // ********************************************************************
    // Latches and pulse control
    // ********************************************************************
    logic [23:0] ref_r, ref_nxt;
    logic [23:0] fb_r, fb_nxt;
    logic [23:0] func_r, func_nxt;
    logic pulse_r, pulse_nxt;
    logic sync_pd_r, sync_pd_nxt;
    logic loaded_r, loaded_nxt;
    psl_pkg::psl_arm_t arm_r, arm_nxt;
    psl_pkg::psl_sel_t sel;

    function automatic logic sync_pd_word(input logic [23:0] w,
        input logic ce);
        sync_pd_word = ce & w[psl_pkg::PD_ENABLE_POS]
            & ~w[psl_pkg::PD_SYNC_POS];
    endfunction

    assign sel = psl_pkg::psl_sel_t'(shift_r[psl_pkg::SEL_LSB +: 2]);

    always_comb begin
        ref_nxt = ref_r;
        fb_nxt = fb_r;
        func_nxt = func_r;
        pulse_nxt = 1'b0;
        sync_pd_nxt = sync_pd_r;
        loaded_nxt = 1'b0;
        arm_nxt = arm_r;
        // Latches are never cleared by CE, only by the global reset
        if (link.strobe_rise) begin
            loaded_nxt = 1'b1;
            case (sel)
                psl_pkg::PSL_SEL_REF: begin
                    ref_nxt = shift_r;
                end
                psl_pkg::PSL_SEL_FB: begin
                    fb_nxt = shift_r;
                    case (arm_r)
                        psl_pkg::PSL_ARMED: begin
                            pulse_nxt = 1'b1;
                            arm_nxt = psl_pkg::PSL_IDLE;
                        end
                        default: begin
                            arm_nxt = psl_pkg::PSL_IDLE;
                        end
                    endcase
                end
                psl_pkg::PSL_SEL_FUNC: begin
                    func_nxt = shift_r;
                    sync_pd_nxt = 1'b0;
                end
                default: begin
                    func_nxt = shift_r;
                    pulse_nxt = 1'b1;
                    arm_nxt = psl_pkg::PSL_ARMED;
                    sync_pd_nxt = sync_pd_word(shift_r, link.ce_s);
                end
            endcase
        end
        // CE pin power-down overrides; a pending sync request is dropped
        if (!link.ce_s) begin
            sync_pd_nxt = 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            shift_r <= psl_pkg::LATCH_RESET;
            ref_r <= psl_pkg::LATCH_RESET;
            fb_r <= psl_pkg::LATCH_RESET;
            func_r <= psl_pkg::LATCH_RESET;
            pulse_r <= 1'b0;
            sync_pd_r <= 1'b0;
            loaded_r <= 1'b0;
            arm_r <= psl_pkg::PSL_IDLE;
        end else begin
            shift_r <= shift_nxt;
            ref_r <= ref_nxt;
            fb_r <= fb_nxt;
            func_r <= func_nxt;
            pulse_r <= pulse_nxt;
            sync_pd_r <= sync_pd_nxt;
            loaded_r <= loaded_nxt;
            arm_r <= arm_nxt;
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    logic cnt_reset;
    logic pd_any;

    // Counter reset bit is a steady hold and never requests power-down
    assign cnt_reset = func_r[psl_pkg::CNT_RESET_POS];
    // Leaving power-down releases the counters together, keeping alignment
    assign pd_any = ~link.ce_s | sync_pd_r;

    always_comb begin
        COUNTER_LOAD = pulse_r | cnt_reset | pd_any;
        PUMP_TRISTATE = pulse_r | cnt_reset | pd_any;
        POWER_DOWN = pd_any;
        LOCK_CLEAR = pd_any;
    end

    assign REF_LATCH = ref_r;
    assign FB_LATCH = fb_r;
    assign FUNC_LATCH = func_r;
    assign INIT_RESET_PULSE = pulse_r;
    assign SYNC_PD_REQ = sync_pd_r;
    assign WORD_LOADED = loaded_r;
endmodule
`default_nettype wire

// >>> src/psl_pkg.sv
// Constants and types shared by the serial latch loader
`default_nettype none
package psl_pkg;
    // ********************************************************************
    // Word layout
    // ********************************************************************
    localparam int WORD_BITS = 24;
    localparam int SEL_LSB = 0;
    localparam int CNT_RESET_POS = 2;
    localparam int PD_ENABLE_POS = 3;
    localparam int PD_SYNC_POS = 21;
    localparam logic [23:0] LATCH_RESET = 24'h000000;
    localparam logic [4:0] BIT_COUNT_RESET = 5'h00;

    // ********************************************************************
    // Latch select codes
    // ********************************************************************
    typedef enum logic [1:0] {
        PSL_SEL_REF  = 2'b00,
        PSL_SEL_FB   = 2'b01,
        PSL_SEL_FUNC = 2'b10,
        PSL_SEL_INIT = 2'b11
    } psl_sel_t;

    // ********************************************************************
    // Re-arm state of the internal reset pulse
    // ********************************************************************
    typedef enum logic [0:0] {
        PSL_IDLE  = 1'b0,
        PSL_ARMED = 1'b1
    } psl_arm_t;
endpackage
`default_nettype wire

// >>> src/psl_link_if.sv
// Link sampling signals passed from the synchroniser to the loader
`default_nettype none
interface psl_link_if;
    logic sclk_rise;
    logic strobe_rise;
    logic data_s;
    logic ce_s;
    modport sync (output sclk_rise, output strobe_rise, output data_s,
        output ce_s);
    modport core (input sclk_rise, input strobe_rise, input data_s,
        input ce_s);
endinterface
`default_nettype wire

// >>> src/psl_pin_sync.sv
// Two-flop synchroniser and edge finder for the serial link pins
`default_nettype none
module psl_pin_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Raw pins
    input wire logic sclk_pin,
    input wire logic data_pin,
    input wire logic strobe_pin,
    input wire logic ce_pin,
    // Sampled link
    psl_link_if.sync link
);
    logic [3:0] meta_r, meta_nxt;
    logic [3:0] sync_r, sync_nxt;
    logic [1:0] prev_r, prev_nxt;

    always_comb begin
        meta_nxt = {ce_pin, strobe_pin, data_pin, sclk_pin};
        sync_nxt = meta_r;
        prev_nxt = {sync_r[2], sync_r[0]};
    end

    // CE resets low so the part starts powered down until the pin is seen
    // Strobe resets high, its idle level, so release gives no false rise
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_r <= 4'h4;
            sync_r <= 4'h4;
            prev_r <= 2'h2;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            prev_r <= prev_nxt;
        end
    end

    assign link.sclk_rise = sync_r[0] & ~prev_r[0];
    assign link.strobe_rise = sync_r[2] & ~prev_r[1];
    assign link.data_s = sync_r[1];
    assign link.ce_s = sync_r[3];
endmodule
`default_nettype wire

// >>> verification/psl_loader_assertions.sv
// Port checks for the serial latch loader
`default_nettype none
module psl_loader_chk (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // Pins
    input wire logic WORD_TRANSFER_STROBE,
    input wire logic CHIP_ENABLE,
    // Outputs
    input wire logic [23:0] REF_LATCH,
    input wire logic COUNTER_LOAD,
    input wire logic PUMP_TRISTATE,
    input wire logic POWER_DOWN,
    input wire logic LOCK_CLEAR,
    input wire logic INIT_RESET_PULSE,
    input wire logic SYNC_PD_REQ,
    input wire logic WORD_LOADED
);
    // ********
    // Checks
    // ********
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    property p_pulse_once;
        INIT_RESET_PULSE |=> !INIT_RESET_PULSE;
    endproperty
    a_pulse_once: assert property (p_pulse_once)
        else $error("reset pulse longer than one cycle");
    property p_pulse_load;
        INIT_RESET_PULSE |-> WORD_LOADED && COUNTER_LOAD && PUMP_TRISTATE;
    endproperty
    a_pulse_load: assert property (p_pulse_load)
        else $error("reset pulse without load or pump off");
    property p_pd_ce;
        $fell(CHIP_ENABLE) |-> ##[1:4] POWER_DOWN;
    endproperty
    a_pd_ce: assert property (p_pd_ce)
        else $error("no power-down after enable low");
    property p_ce_hi;
        CHIP_ENABLE [*4] ##0 !SYNC_PD_REQ |-> !POWER_DOWN;
    endproperty
    a_ce_hi: assert property (p_ce_hi)
        else $error("power-down while enabled");
    property p_pd_load;
        POWER_DOWN |-> COUNTER_LOAD && LOCK_CLEAR && PUMP_TRISTATE;
    endproperty
    a_pd_load: assert property (p_pd_load)
        else $error("power-down without counter load");
    property p_sync;
        SYNC_PD_REQ |-> POWER_DOWN;
    endproperty
    a_sync: assert property (p_sync)
        else $error("sync request without power-down");
    property p_keep;
        $changed(REF_LATCH) |-> WORD_LOADED;
    endproperty
    a_keep: assert property (p_keep)
        else $error("latch changed without a transfer");
    property p_strobe;
        $rose(WORD_TRANSFER_STROBE) |-> ##[2:4] WORD_LOADED;
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("strobe rise without transfer");
endmodule
bind psl_loader psl_loader_chk psl_loader_chk_inst (.CLK(CLK),
    .RESET(RESET), .WORD_TRANSFER_STROBE(WORD_TRANSFER_STROBE),
    .CHIP_ENABLE(CHIP_ENABLE), .REF_LATCH(REF_LATCH),
    .COUNTER_LOAD(COUNTER_LOAD), .PUMP_TRISTATE(PUMP_TRISTATE),
    .POWER_DOWN(POWER_DOWN), .LOCK_CLEAR(LOCK_CLEAR),
    .INIT_RESET_PULSE(INIT_RESET_PULSE), .SYNC_PD_REQ(SYNC_PD_REQ),
    .WORD_LOADED(WORD_LOADED));
`default_nettype wire

// >>> verification/psl_host.sv
// Host model that shifts words over the three-wire link
`default_nettype none
module psl_host (
    // Clock
    input wire logic clk,
    // Link
    output logic sclk,
    output logic sdata,
    output logic strobe
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sclk = 1'b0;
        sdata = 1'b0;
        strobe = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Half period of four cycles gives a 320 ns clock period, far below the top rate
    task automatic send(input logic [23:0] w);
        strobe = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sdata = w[i];
            tick(4);
            sclk = 1'b1;
            tick(4);
            sclk = 1'b0;
        end
        sdata = ~w[0];
        tick(4);
        strobe = 1'b1;
        tick(8);
    endtask
endmodule
`default_nettype wire

// >>> verification/psl_loader_tb.sv
// Self-checking bench for the serial latch loader
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin \
    mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module psl_loader_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic CLK = 1'b0;
    logic RESET = 1'b1;
    logic ce = 1'b1;
    logic sclk, sdata, strobe, cload, pdown, lclr, ipulse, spd;
    logic ptri, wl;
    int loads = 0;
    logic [23:0] ref_q, fb_q, func_q;
    int mismatches = 0;
    int num_checks = 0;
    int pulses = 0;
    always #20 CLK = ~CLK;
    always @(posedge CLK) if (ipulse === 1'b1) pulses++;
    always @(posedge CLK) if (wl === 1'b1) loads++;
    psl_host psl_host_inst (.clk(CLK), .sclk(sclk), .sdata(sdata),
        .strobe(strobe));
    psl_loader psl_loader_inst (.CLK(CLK), .RESET(RESET), .SCLK(sclk),
        .SDATA(sdata), .WORD_TRANSFER_STROBE(strobe), .CHIP_ENABLE(ce),
        .REF_LATCH(ref_q), .FB_LATCH(fb_q), .FUNC_LATCH(func_q),
        .COUNTER_LOAD(cload), .PUMP_TRISTATE(ptri), .POWER_DOWN(pdown),
        .LOCK_CLEAR(lclr), .INIT_RESET_PULSE(ipulse),
        .SYNC_PD_REQ(spd), .WORD_LOADED(wl));
    task automatic wr(input logic [23:0] w);
        psl_host_inst.send(w);
    endtask
    task automatic tally_and_finish;
        if (mismatches == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ********
    // Tests
    // ********
    initial begin
        repeat (3) @(posedge CLK);
        #1 RESET = 1'b0;
        psl_host_inst.tick(4);
        `CHK(pdown, 1'b0)
        wr(24'h00000B);
        `CHK(func_q, 24'h00000B)
        `CHK(pulses, 1)
        `CHK(loads, 1)
        `CHK(spd, 1'b1)
        `CHK(pdown, 1'b1)
        wr(24'h000002);
        `CHK(func_q, 24'h000002)
        `CHK(spd, 1'b0)
        wr(24'h000004);
        `CHK(ref_q, 24'h000004)
        wr(24'h000105);
        `CHK(fb_q, 24'h000105)
        `CHK(pulses, 2)
        wr(24'h000205);
        `CHK(pulses, 2)
        wr(24'h000003);
        wr(24'h000305);
        `CHK(pulses, 4)
        wr(24'h000006);
        `CHK(cload, 1'b1)
        `CHK(ptri, 1'b1)
        `CHK(pdown, 1'b0)
        wr(24'hABCD00);
        wr(24'h000405);
        `CHK(pulses, 4)
        wr(24'h000002);
        `CHK(cload, 1'b0)
        `CHK(ptri, 1'b0)
        ce = 1'b0;
        psl_host_inst.tick(4);
        `CHK(lclr, 1'b1)
        wr(24'h123400);
        `CHK(ref_q, 24'h123400)
        ce = 1'b1;
        psl_host_inst.tick(4);
        `CHK(cload, 1'b0)
        `CHK(func_q, 24'h000002)
        tally_and_finish;
    end
    // Twelve words take about 98 us
    initial begin
        #1000000;
        mismatches++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
